// ==== hdl/ccd_map.svh ====
// constants of the coil current serial slave: address, field positions, reset values, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// frame layout
`define CCD_SLAVE_ADDR 7'h33
`define CCD_DIR_WRITE 1'b0
`define CCD_BITS_PER_BYTE 4'h8
`define CCD_FIRST_BYTE 2'h0
`define CCD_LAST_BYTE 2'h3

// second byte: standby flag and code bits 9..4
`define CCD_STANDBY_POS 7
`define CCD_CODE_HI_MSB 5
`define CCD_CODE_HI_LSB 0
// third byte: code bits 3..0
`define CCD_CODE_LO_MSB 7
`define CCD_CODE_LO_LSB 4
// fourth byte: slope step size and step time
`define CCD_SIZE_MSB 7
`define CCD_SIZE_LSB 5
`define CCD_TIME_MSB 4
`define CCD_TIME_LSB 2

// reset values
`define CCD_STANDBY_RST 1'b0
`define CCD_CODE_RST 10'h000
`define CCD_SIZE_RST 3'h0
`define CCD_TIME_RST 3'h0
`define CCD_SLOPE_OFF 3'h0

// timing: base step time doubles with each step-time code
`define CCD_CLK_PERIOD_NS 10
`define CCD_STEP_BASE_NS 32000
`define CCD_STEP_BASE_CYCLES (`CCD_STEP_BASE_NS / `CCD_CLK_PERIOD_NS)

`endif

// ==== hdl/ccd_pkg.sv ====
// types shared by the coil current serial slave and its slope stepper
// assumes ccd_map.svh is on the include path
`include "ccd_map.svh"

package ccd_pkg;

    // receiver states, gray along idle -> receive -> acknowledge
    typedef enum logic [1:0] {
        CCD_IDLE = 2'h0,
        CCD_RECV = 2'h1,
        CCD_ACK  = 2'h3,
        CCD_SKIP = 2'h2
    } ccd_state_e;

    // settings taken from one complete frame
    typedef struct packed {
        logic       standby;
        logic [9:0] code;
        logic [2:0] step_size;
        logic [2:0] step_time;
    } ccd_setting_s;

endpackage

// ==== hdl/ccd_slope.sv ====
// slope stepper: walks the output current code toward the received target
// assumes settings come from logic on the same clock, already committed as one frame
`timescale 1ns/100ps
`default_nettype none
`include "ccd_map.svh"

module ccd_slope #(
    parameter int CODE_W = 10,
    parameter int BASE_CYCLES = `CCD_STEP_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ccd_pkg::ccd_setting_s setting,
    output logic [CODE_W-1:0] current_level,
    output logic standby_active
);

    localparam int TMR_W = 24;

    logic [CODE_W-1:0] level_reg, level_next;
    logic [TMR_W-1:0] timer_reg, timer_next;
    logic zero_req;

    // step in code units: one lsb at size 1, doubling per size code
    function automatic logic [CODE_W-1:0] step_of(input logic [2:0] size);
        step_of = CODE_W'(1) << (size - 3'h1);
    endfunction

    // step duration in cycles: base time doubled per time code
    function automatic logic [TMR_W-1:0] period_of(input logic [2:0] tm);
        period_of = TMR_W'(BASE_CYCLES) << tm;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // zero current request
    assign zero_req = setting.standby || (setting.code == `CCD_CODE_RST);

    // next level: standby or code zero drops at once, slope off jumps, else stepped
    always_comb begin
        level_next = level_reg;
        timer_next = timer_reg;
        if (zero_req) begin
            level_next = '0;
            timer_next = '0;
        end else if (setting.step_size == `CCD_SLOPE_OFF) begin
            level_next = setting.code;
            timer_next = '0;
        end else if (level_reg != setting.code) begin
            if (timer_reg == '0) begin
                timer_next = period_of(setting.step_time) - TMR_W'(1);
                if (setting.code > level_reg) begin
                    level_next = (setting.code - level_reg > step_of(setting.step_size)) ?
                        level_reg + step_of(setting.step_size) : setting.code;
                end else begin
                    level_next = (level_reg - setting.code > step_of(setting.step_size)) ?
                        level_reg - step_of(setting.step_size) : setting.code;
                end
            end else begin
                timer_next = timer_reg - TMR_W'(1);
            end
        end else begin
            timer_next = '0;
        end
    end

    // registers of the stepper
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= '0;
            timer_reg <= '0;
            standby_active <= 1'b1;
        end else begin
            level_reg <= level_next;
            timer_reg <= timer_next;
            standby_active <= zero_req;
        end
    end

    assign current_level = level_reg;

    //////////////////////////////////////////////////////////////////////////
    a_zero_standby:
    assert property (@(posedge clk) disable iff (!rst_n)
        zero_req |=> (current_level == '0) && standby_active)
        else $error("output not zero under standby");

    a_slope_off:
    assert property (@(posedge clk) disable iff (!rst_n)
        (!zero_req && setting.step_size == `CCD_SLOPE_OFF) |=> current_level == $past(setting.code))
        else $error("slope off did not follow code");

    a_step_bound:
    assert property (@(posedge clk) disable iff (!rst_n)
        (!zero_req && setting.step_size != `CCD_SLOPE_OFF && level_reg != setting.code && timer_reg != '0)
        |=> $stable(level_reg))
        else $error("level moved before step time ran out");

endmodule
`default_nettype wire

// ==== hdl/ccd_i2c_slave.sv ====
// coil current serial write slave: receives address plus three data bytes, drives the current code
// assumes scl, sda and the enable pin are asynchronous pins; sda is open drain, resolved outside
// How it works
// - both lines high means bus idle
// - sda falling while scl high starts
// - sda rising while scl high stops
// - whole bytes, each followed by acknowledge
// - first byte must be address 0110011, write
// - write only, never returns read data
// - pull sda low after eighth falling edge
// - release sda at ninth falling edge
// - frame is address plus three data bytes
// - byte two standby and code high, three low
// - byte four step size and step time
// - standby bit forces current to zero
// - enable low clears all received settings
// - enable low restores standby 0, code 0
// - code zero means zero output current
// - code sets current linearly to full scale
// - slope steps by size and time fields
`timescale 1ns/100ps
`default_nettype none
`include "ccd_map.svh"

module ccd_i2c_slave #(
    parameter int STEP_BASE_CYCLES = `CCD_STEP_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_enable_reset_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output ccd_pkg::ccd_setting_s setting,
    output logic [9:0] current_level,
    output logic standby_active
);

    localparam logic [7:0] ADDR_BYTE = {`CCD_SLAVE_ADDR, `CCD_DIR_WRITE};

    logic scl_ff1, scl_s, scl_p;
    logic sda_ff1, sda_s, sda_p;
    logic enable_ff1, enable_s;
    logic scl_rise, scl_fall, start_evt, stop_evt;

    ccd_pkg::ccd_state_e state_reg, state_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [1:0] byte_idx_reg, byte_idx_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] byte1_reg, byte1_next;
    logic [7:0] byte2_reg, byte2_next;
    logic drive_reg, drive_next;
    logic commit;
    ccd_pkg::ccd_setting_s setting_reg, setting_next, pending;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_ff1 <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_ff1 <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
            enable_ff1 <= 1'b0;
            enable_s <= 1'b0;
        end else begin
            scl_ff1 <= scl_in;
            scl_s <= scl_ff1;
            scl_p <= scl_s;
            sda_ff1 <= sda_in;
            sda_s <= sda_ff1;
            sda_p <= sda_s;
            enable_ff1 <= chip_enable_reset_pin;
            enable_s <= enable_ff1;
        end
    end

    // edges of the synchronised lines; both lines share one delay so order holds
    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign start_evt = scl_s && scl_p && sda_p && !sda_s;
    assign stop_evt = scl_s && scl_p && !sda_p && sda_s;

    // frame fields assembled from bytes two, three and four
    always_comb begin
        pending.standby = byte1_reg[`CCD_STANDBY_POS];
        pending.code = {byte1_reg[`CCD_CODE_HI_MSB:`CCD_CODE_HI_LSB], byte2_reg[`CCD_CODE_LO_MSB:`CCD_CODE_LO_LSB]};
        pending.step_size = shift_reg[`CCD_SIZE_MSB:`CCD_SIZE_LSB];
        pending.step_time = shift_reg[`CCD_TIME_MSB:`CCD_TIME_LSB];
    end

    //////////////////////////////////////////////////////////////////////////
    // receiver next state; sda is sampled on rising scl, ack driven between falls
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        byte_idx_next = byte_idx_reg;
        shift_next = shift_reg;
        byte1_next = byte1_reg;
        byte2_next = byte2_reg;
        drive_next = drive_reg;
        setting_next = setting_reg;
        commit = 1'b0;
        if (!enable_s) begin
            state_next = ccd_pkg::CCD_IDLE;
            drive_next = 1'b0;
            bit_cnt_next = 4'h0;
            byte_idx_next = `CCD_FIRST_BYTE;
            setting_next = '{standby: `CCD_STANDBY_RST, code: `CCD_CODE_RST,
                step_size: `CCD_SIZE_RST, step_time: `CCD_TIME_RST};
        end else if (start_evt) begin
            // a repeated start also restarts the frame
            state_next = ccd_pkg::CCD_RECV;
            drive_next = 1'b0;
            bit_cnt_next = 4'h0;
            byte_idx_next = `CCD_FIRST_BYTE;
        end else if (stop_evt) begin
            state_next = ccd_pkg::CCD_IDLE;
            drive_next = 1'b0;
        end else begin
            case (state_reg)
                ccd_pkg::CCD_RECV: begin
                    if (scl_rise && bit_cnt_reg != `CCD_BITS_PER_BYTE) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == `CCD_BITS_PER_BYTE) begin
                        if (byte_idx_reg == `CCD_FIRST_BYTE && shift_reg != ADDR_BYTE) begin
                            state_next = ccd_pkg::CCD_SKIP;
                        end else begin
                            state_next = ccd_pkg::CCD_ACK;
                            drive_next = 1'b1;
                            if (byte_idx_reg == 2'h1) begin
                                byte1_next = shift_reg;
                            end
                            if (byte_idx_reg == 2'h2) begin
                                byte2_next = shift_reg;
                            end
                        end
                    end
                end
                ccd_pkg::CCD_ACK: begin
                    if (scl_fall) begin
                        drive_next = 1'b0;
                        bit_cnt_next = 4'h0;
                        if (byte_idx_reg == `CCD_LAST_BYTE) begin
                            commit = 1'b1;
                            setting_next = pending;
                            state_next = ccd_pkg::CCD_SKIP;
                        end else begin
                            byte_idx_next = byte_idx_reg + 2'h1;
                            state_next = ccd_pkg::CCD_RECV;
                        end
                    end
                end
                ccd_pkg::CCD_SKIP: begin
                    drive_next = 1'b0;
                end
                ccd_pkg::CCD_IDLE: begin
                    drive_next = 1'b0;
                end
                default: begin
                    state_next = ccd_pkg::CCD_IDLE;
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    // receiver registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ccd_pkg::CCD_IDLE;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            shift_reg <= 8'h00;
            byte1_reg <= 8'h00;
            byte2_reg <= 8'h00;
            drive_reg <= 1'b0;
            setting_reg <= '{standby: `CCD_STANDBY_RST, code: `CCD_CODE_RST,
                step_size: `CCD_SIZE_RST, step_time: `CCD_TIME_RST};
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            byte_idx_reg <= byte_idx_next;
            shift_reg <= shift_next;
            byte1_reg <= byte1_next;
            byte2_reg <= byte2_next;
            drive_reg <= drive_next;
            setting_reg <= setting_next;
        end
    end

    // only ever drives low for ack
    assign sda_out = 1'b0;
    assign sda_oe = drive_reg;
    assign setting = setting_reg;

    //////////////////////////////////////////////////////////////////////////
    // current stepping on the committed settings
    ccd_slope #(
        .CODE_W(10),
        .BASE_CYCLES(STEP_BASE_CYCLES)
    ) u_slope (
        .clk(clk),
        .rst_n(rst_n),
        .setting(setting_reg),
        .current_level(current_level),
        .standby_active(standby_active)
    );

    //////////////////////////////////////////////////////////////////////////
    a_idle_release:
    assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ccd_pkg::CCD_IDLE |-> !sda_oe)
        else $error("sda driven while idle");

    a_start_detect:
    assert property (@(posedge clk) disable iff (!rst_n)
        (enable_s && start_evt) |=> state_reg == ccd_pkg::CCD_RECV && bit_cnt_reg == 4'h0 && byte_idx_reg == 2'h0)
        else $error("start not taken");

    a_stop_detect:
    assert property (@(posedge clk) disable iff (!rst_n)
        (enable_s && stop_evt && !start_evt) |=> state_reg == ccd_pkg::CCD_IDLE && !sda_oe)
        else $error("stop not taken");

    a_ack_after_eight:
    assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sda_oe) |-> $past(bit_cnt_reg) == `CCD_BITS_PER_BYTE && $past(scl_fall))
        else $error("ack without eight bits");

    a_addr_reject:
    assert property (@(posedge clk) disable iff (!rst_n)
        (enable_s && !start_evt && !stop_evt && state_reg == ccd_pkg::CCD_RECV && scl_fall
         && bit_cnt_reg == `CCD_BITS_PER_BYTE && byte_idx_reg == 2'h0 && shift_reg != ADDR_BYTE)
        |=> state_reg == ccd_pkg::CCD_SKIP && !sda_oe)
        else $error("foreign address acknowledged");

    a_only_ack_drive:
    assert property (@(posedge clk) disable iff (!rst_n)
        sda_oe |-> state_reg == ccd_pkg::CCD_ACK && sda_out == 1'b0)
        else $error("sda driven outside ack");

    a_ack_drive:
    assert property (@(posedge clk) disable iff (!rst_n)
        (enable_s && !start_evt && !stop_evt && state_reg == ccd_pkg::CCD_RECV && scl_fall
         && bit_cnt_reg == `CCD_BITS_PER_BYTE && (byte_idx_reg != 2'h0 || shift_reg == ADDR_BYTE))
        |=> sda_oe)
        else $error("byte not acknowledged");

    a_ack_release:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ccd_pkg::CCD_ACK && scl_fall) |=> !sda_oe)
        else $error("sda held past ninth fall");

    a_frame_commit:
    assert property (@(posedge clk) disable iff (!rst_n)
        (enable_s && !commit) |=> $stable(setting_reg))
        else $error("settings changed outside frame commit");

    a_enable_clear:
    assert property (@(posedge clk) disable iff (!rst_n)
        !enable_s |=> setting_reg == '0 && state_reg == ccd_pkg::CCD_IDLE && !sda_oe)
        else $error("enable low did not clear");

endmodule
`default_nettype wire

// ==== tb/ccd_master.sv ====
// two-wire bus master model for the coil current slave: start, bytes with ack, stop
// assumes sda_line is the resolved open-drain line with a pull-up, scl is driven push-pull
`timescale 1ns/100ps
`default_nettype none

module ccd_master (
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic put_bit(input logic b);
        #20 sda_low = !b;
        #20 scl = 1'b1;
        #40 scl = 1'b0;
    endtask

    // one frame of n bytes, msb byte first; ack and release seen per byte
    task automatic frame(input logic [31:0] data, input int n, output logic [3:0] ack, output logic [3:0] rel);
        logic [31:0] d;
        int i;
        int k;
        d = data;
        ack = 4'hf;
        rel = 4'hf;
        #3 sda_low = 1'b1;
        #40 scl = 1'b0;
        for (i = 0; i < n; i++) begin
            for (k = 0; k < 8; k++) begin
                put_bit(d[31]);
                d = d << 1;
            end
            // master lets go for the ack
            #20 sda_low = 1'b0;
            #20 scl = 1'b1;
            #20 ack[i] = sda_line;
            #20 scl = 1'b0;
            // line should be back high once the slave lets go
            #40 rel[i] = sda_line;
        end
        #20 sda_low = 1'b1;
        #20 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask
endmodule

`default_nettype wire

// ==== tb/ccd_i2c_slave_test.sv ====
// self-checking bench for the coil current serial write slave
// assumes the master model drives the link at 80 ns per bit and the step base is shortened
`timescale 1ns/100ps
`default_nettype none

module ccd_i2c_slave_test;
    localparam int STEP = 4;
    logic clk;
    logic rst_n;
    logic en;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic standby_active;
    logic [9:0] current_level;
    ccd_pkg::ccd_setting_s setting;
    wire sda_line;
    logic [3:0] ack;
    logic [3:0] rel;
    int n_mismatch;
    int n_compared;

    // open drain: low if either party pulls, pull-up otherwise
    assign sda_line = !(sda_low || (sda_oe && !sda_out));

    ccd_i2c_slave #(.STEP_BASE_CYCLES(STEP)) i_ccd_i2c_slave (
        .clk(clk), .rst_n(rst_n), .chip_enable_reset_pin(en), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .setting(setting), .current_level(current_level),
        .standby_active(standby_active)
    );

    ccd_master i_ccd_master (.sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // ignored bits are sent as ones so a leak shows up
    function automatic logic [31:0] mk(input logic s, input logic [9:0] c, input logic [2:0] z, input logic [2:0] t);
        return {8'h66, s, 1'b1, c[9:4], c[3:0], 4'hf, z, t, 2'h3};
    endfunction

    task automatic send(input logic [31:0] data, input int n, input int settle);
        i_ccd_master.frame(data, n, ack, rel);
        repeat (settle) tick();
    endtask

    task automatic end_of_test();
        $display("mismatches %0d, compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_state();
        chk(setting === 17'h00000, "settings not cleared");
        chk(current_level === 10'h000 && standby_active === 1'b1, "output not idle");
    endtask

    task automatic t_code_zero();
        send(mk(1'b0, 10'h000, 3'h0, 3'h0), 4, 10);
        chk(ack === 4'h0, "code zero frame not acked");
        chk(standby_active === 1'b1 && current_level === 10'h000, "code zero not standby");
    endtask

    task automatic t_write();
        send(mk(1'b0, 10'h2a5, 3'h0, 3'h0), 4, 10);
        chk(ack === 4'h0, "frame not acked");
        chk(rel === 4'hf, "sda held after ack");
        chk(setting === {1'b0, 10'h2a5, 3'h0, 3'h0}, "fields misplaced");
        chk(current_level === 10'h2a5 && standby_active === 1'b0, "level not code");
        send({8'h66, 8'h00, 8'h00, 3'h5, 3'h6, 2'h0}, 4, 10);
        chk(setting === {1'b0, 10'h000, 3'h5, 3'h6}, "slope fields misplaced");
        send(mk(1'b0, 10'h2a5, 3'h0, 3'h0), 4, 10);
    endtask

    task automatic t_bad_addr();
        send({8'h68, 24'h3fff03}, 4, 10);
        chk(ack === 4'hf, "foreign address acked");
        send({8'h67, 24'h3fff03}, 4, 10);
        chk(ack === 4'hf, "read request acked");
        chk(setting === {1'b0, 10'h2a5, 3'h0, 3'h0}, "refused frame changed settings");
    endtask

    task automatic t_partial();
        send(mk(1'b0, 10'h111, 3'h0, 3'h0), 3, 10);
        chk(ack[2:0] === 3'h0, "partial bytes not acked");
        chk(setting === {1'b0, 10'h2a5, 3'h0, 3'h0}, "partial frame committed");
    endtask

    task automatic t_standby();
        send(mk(1'b1, 10'h155, 3'h2, 3'h1), 4, 10);
        chk(setting.standby === 1'b1, "standby not taken");
        chk(current_level === 10'h000 && standby_active === 1'b1, "standby not zero");
    endtask

    task automatic t_slope();
        logic [9:0] last;
        int n;
        send(mk(1'b0, 10'h008, 3'h1, 3'h1), 4, 0);
        chk(current_level > 10'h000 && current_level < 10'h008, "no ramp");
        last = current_level;
        n = 0;
        while (current_level === last && n < 40) begin
            tick();
            n++;
        end
        last = current_level;
        n = 0;
        while (current_level === last && n < 40) begin
            tick();
            n++;
        end
        chk(n == 2 * STEP, "step time wrong");
        chk(current_level === last + 10'h001, "step size wrong");
        repeat (80) tick();
        chk(current_level === 10'h008, "ramp not clamped at target");
    endtask

    task automatic t_enable();
        @(posedge clk);
        en <= 1'b0;
        repeat (6) tick();
        t_reset_state();
        // a frame while disabled must be ignored entirely
        send(mk(1'b0, 10'h0aa, 3'h0, 3'h0), 4, 10);
        chk(ack === 4'hf, "frame acked while disabled");
        t_reset_state();
        @(posedge clk);
        en <= 1'b1;
        repeat (6) tick();
        t_reset_state();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rst_n = 1'b0;
        en = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        en <= 1'b1;
        repeat (6) tick();
        t_reset_state();
        t_code_zero();
        t_write();
        t_bad_addr();
        t_partial();
        t_standby();
        t_slope();
        t_enable();
        end_of_test();
    end

    // a hang past the bound counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        $display("mismatch at %0t: run did not finish", $time);
        end_of_test();
    end
endmodule

`default_nettype wire
